/* verilog/fsc_consts.svh */
// constants of the flash status and configuration register bank
`ifndef FSC_CONSTS_SVH
`define FSC_CONSTS_SVH

// ----------------------------------------
// primary status field positions
// ----------------------------------------
`define FSC_STAT_WRITE_DISABLE 7
`define FSC_STAT_PROG_ERR 6
`define FSC_STAT_ERASE_ERR 5
`define FSC_STAT_RANGE_HI 4
`define FSC_STAT_RANGE_LO 2
`define FSC_STAT_WR_ENABLE 1
`define FSC_STAT_BUSY 0

// ----------------------------------------
// device configuration field positions
// ----------------------------------------
`define FSC_CFG_LAT_HI 7
`define FSC_CFG_LAT_LO 6
`define FSC_CFG_ORIGIN 5
`define FSC_CFG_VOLATILITY 3
`define FSC_CFG_QUAD 1
`define FSC_CFG_FREEZE 0

// ----------------------------------------
// suspend status field positions
// ----------------------------------------
`define FSC_SUSP_ERASE 1
`define FSC_SUSP_PROG 0

// ----------------------------------------
// reset values
// ----------------------------------------
`define FSC_STAT_RST 8'h00
`define FSC_CFG_RST 8'h00
`define FSC_SUSP_RST 8'h00
`define FSC_RANGE_RST 3'h0
`define FSC_RANGE_VOL_DEFAULT 3'h7
`define FSC_LAT_RST 2'h0

// ----------------------------------------
// array geometry and timing
// ----------------------------------------
`define FSC_SECTOR_COUNT 10'h100
`define FSC_RANGE_ALL 3'h7
`define FSC_CLK_PERIOD_NS 25
`define FSC_REG_WRITE_TIME_NS 2000
`define FSC_REG_WRITE_CYC ((`FSC_REG_WRITE_TIME_NS + `FSC_CLK_PERIOD_NS - 1) / `FSC_CLK_PERIOD_NS)

`endif

/* verilog/fsc_pkg.sv */
// types of the flash status and configuration register bank
package fsc_pkg;

	typedef enum logic [2:0] {
		FSC_CMD_WR_ENABLE,
		FSC_CMD_WR_DISABLE,
		FSC_CMD_REG_WRITE,
		FSC_CMD_PROGRAM,
		FSC_CMD_ERASE,
		FSC_CMD_SUSPEND,
		FSC_CMD_RESUME,
		FSC_CMD_CLEAR_ERR
	} fsc_cmd_t;

	// data[15:8] new primary status, data[7:0] new configuration
	typedef struct packed {
		fsc_cmd_t cmd;
		logic [15:0] data;
		logic [7:0] sector;
	} fsc_cmd_req_t;

	typedef struct packed {
		logic [7:0] status;
		logic [7:0] cfg;
		logic [7:0] susp;
	} fsc_regs_t;

	typedef enum {
		FSC_ST_IDLE,
		FSC_ST_REG_WRITE,
		FSC_ST_ARRAY,
		FSC_ST_SUSPENDED
	} fsc_state_t;

endpackage

/* verilog/fsc_regs.sv */
// flash status and configuration register bank with link crossing
// Function
// R1: write-disable plus low protect pin blocks writes
// R2: write latch gates register write, program, erase
// R3: only enable/disable commands change write latch
// R4: busy reads one during any operation
// R5: busy zero only when idle, accepting commands; the code also clears it while suspended
// R6: program and erase error flags, read-only
// R7: protect range bits guard contiguous sectors
// R8: volatility bit, volatile range defaults to ones
// R9: origin bit picks bottom or top range
// R10: latency code bits set read dummy cycles
// R11: quad bit selects four-lane operation
// R12: freeze bit locks range and origin
// R13: erase-suspend flag while erase suspended
// R14: program-suspend flag while program suspended
// R15: reserved bits read zero, ignore writes
`timescale 1ns/1ps
`include "fsc_consts.svh"

module fsc_regs (
	// core clock, reset, enable
	input wire logic I_CLK,
	input wire logic I_ARST_N,
	input wire logic I_CE,
	// link side, on the serial clock
	input wire logic I_LINK_CLK,
	input wire logic I_LINK_VALID,
	input wire fsc_pkg::fsc_cmd_req_t I_LINK_REQ,
	output logic O_LINK_READY,
	output fsc_pkg::fsc_regs_t O_LINK_REGS,
	// protect pin, active low
	input wire logic I_WP_N,
	// array machinery
	input wire logic I_ARRAY_DONE,
	input wire logic I_ARRAY_FAIL,
	output logic O_ARRAY_REQ,
	output logic O_ARRAY_ERASE,
	output logic [7:0] O_ARRAY_SECTOR,
	output logic O_ARRAY_HOLD,
	// read path configuration and busy flag
	output logic [1:0] O_LATENCY_CODE,
	output logic O_QUAD_MODE,
	output logic O_BUSY
);

	// ----------------------------------------
	// link domain: command capture
	// ----------------------------------------
	logic lk_ce_m_q;
	logic lk_ce_q;
	logic lk_ack_m_q;
	logic lk_ack_q;
	logic lk_req_tgl_q;
	fsc_pkg::fsc_cmd_req_t lk_req_q;
	logic lk_accept;
	// core flops read here, held still by the toggle handshakes
	logic co_seen_q;
	logic co_snap_tgl_q;
	fsc_pkg::fsc_regs_t co_snap_q;

	always_ff @(posedge I_LINK_CLK or negedge I_ARST_N)
	begin
		if (!I_ARST_N)
		begin
			lk_ce_m_q <= 1'b0;
			lk_ce_q <= 1'b0;
		end
		else
		begin
			lk_ce_m_q <= I_CE;
			lk_ce_q <= lk_ce_m_q;
		end
	end

	assign lk_accept = lk_ce_q & I_LINK_VALID & O_LINK_READY;

	always_ff @(posedge I_LINK_CLK or negedge I_ARST_N)
	begin
		if (!I_ARST_N)
		begin
			lk_ack_m_q <= 1'b0;
			lk_ack_q <= 1'b0;
			lk_req_tgl_q <= 1'b0;
			lk_req_q <= '0;
			O_LINK_READY <= 1'b0;
		end
		else if (lk_ce_q)
		begin
			lk_ack_m_q <= co_seen_q;
			lk_ack_q <= lk_ack_m_q;
			if (lk_accept)
			begin
				lk_req_q <= I_LINK_REQ;
				lk_req_tgl_q <= ~lk_req_tgl_q;
			end
			// one command in flight; ready drops the cycle after a take
			O_LINK_READY <= ~lk_accept & (lk_req_tgl_q == lk_ack_q);
		end
	end

	// ----------------------------------------
	// link domain: register snapshot
	// ----------------------------------------
	logic lk_snap_m_q;
	logic lk_snap_q;
	logic lk_seen_q;

	always_ff @(posedge I_LINK_CLK or negedge I_ARST_N)
	begin
		if (!I_ARST_N)
		begin
			lk_snap_m_q <= 1'b0;
			lk_snap_q <= 1'b0;
			lk_seen_q <= 1'b0;
			O_LINK_REGS <= {`FSC_STAT_RST, `FSC_CFG_RST, `FSC_SUSP_RST};
		end
		else if (lk_ce_q)
		begin
			lk_snap_m_q <= co_snap_tgl_q;
			lk_snap_q <= lk_snap_m_q;
			// snapshot word is held still until seen is returned
			if (lk_snap_q != lk_seen_q)
			begin
				O_LINK_REGS <= co_snap_q;
				lk_seen_q <= lk_snap_q;
			end
		end
	end

	// ----------------------------------------
	// core domain: synchronisers
	// ----------------------------------------
	logic co_req_m_q;
	logic co_req_q;
	logic co_wp_m_q;
	logic co_wp_n_q;
	logic co_sack_m_q;
	logic co_sack_q;

	always_ff @(posedge I_CLK or negedge I_ARST_N)
	begin
		if (!I_ARST_N)
		begin
			co_req_m_q <= 1'b0;
			co_req_q <= 1'b0;
			co_seen_q <= 1'b0;
			// pin idles high, so no false lock after reset
			co_wp_m_q <= 1'b1;
			co_wp_n_q <= 1'b1;
			co_sack_m_q <= 1'b0;
			co_sack_q <= 1'b0;
		end
		else if (I_CE)
		begin
			co_req_m_q <= lk_req_tgl_q;
			co_req_q <= co_req_m_q;
			co_seen_q <= co_req_q;
			co_wp_m_q <= I_WP_N;
			co_wp_n_q <= co_wp_m_q;
			co_sack_m_q <= lk_seen_q;
			co_sack_q <= co_sack_m_q;
		end
	end

	// ----------------------------------------
	// core domain: command decode
	// ----------------------------------------
	fsc_pkg::fsc_state_t state_q;
	fsc_pkg::fsc_state_t state_d;
	logic wr_disable_q;
	logic prog_err_q;
	logic erase_err_q;
	logic [2:0] range_q;
	logic wr_latch_q;
	logic [1:0] lat_q;
	logic origin_q;
	logic volatile_q;
	logic quad_q;
	logic freeze_q;
	logic erase_kind_q;
	logic [7:0] sector_q;
	logic [7:0] wr_cnt_q;
	logic go;
	logic idle;
	logic wp_lock;
	logic do_wen;
	logic do_wdis;
	logic do_rw;
	logic do_op;
	logic do_susp;
	logic do_resume;
	logic do_clr;
	logic [9:0] prot_cnt;
	logic prot_hit;
	logic [7:0] new_stat;
	logic [7:0] new_cfg;

	assign go = (co_req_q != co_seen_q);
	assign idle = (state_q == fsc_pkg::FSC_ST_IDLE);
	assign new_stat = lk_req_q.data[15:8];
	assign new_cfg = lk_req_q.data[7:0];
	// R1: disable bit with low pin
	assign wp_lock = wr_disable_q & ~co_wp_n_q;
	// R2: latch gates writes
	assign do_rw = go & idle & wr_latch_q & ~wp_lock
		& (lk_req_q.cmd == fsc_pkg::FSC_CMD_REG_WRITE);
	assign do_op = go & idle & wr_latch_q
		& ((lk_req_q.cmd == fsc_pkg::FSC_CMD_PROGRAM)
		| (lk_req_q.cmd == fsc_pkg::FSC_CMD_ERASE));
	assign do_wen = go & ~O_BUSY
		& (lk_req_q.cmd == fsc_pkg::FSC_CMD_WR_ENABLE);
	assign do_wdis = go & ~O_BUSY
		& (lk_req_q.cmd == fsc_pkg::FSC_CMD_WR_DISABLE);
	assign do_susp = go & (state_q == fsc_pkg::FSC_ST_ARRAY)
		& (lk_req_q.cmd == fsc_pkg::FSC_CMD_SUSPEND);
	assign do_resume = go & (state_q == fsc_pkg::FSC_ST_SUSPENDED)
		& (lk_req_q.cmd == fsc_pkg::FSC_CMD_RESUME);
	assign do_clr = go & idle
		& (lk_req_q.cmd == fsc_pkg::FSC_CMD_CLEAR_ERR);

	// R7: protected sector count
	always_comb
	begin
		if (range_q == `FSC_RANGE_RST)
			prot_cnt = 10'h000;
		else if (range_q == `FSC_RANGE_ALL)
			prot_cnt = `FSC_SECTOR_COUNT;
		else
			prot_cnt = 10'h002 << range_q;
	end

	// R9: bottom or top of the array
	assign prot_hit = origin_q ? ({2'h0, lk_req_q.sector} < prot_cnt)
		: ({2'h0, lk_req_q.sector} + prot_cnt >= `FSC_SECTOR_COUNT);

	// ----------------------------------------
	// core domain: operation sequencer
	// ----------------------------------------
	always_comb
	begin
		state_d = state_q;
		case (state_q)
			fsc_pkg::FSC_ST_IDLE:
				if (do_rw)
					state_d = fsc_pkg::FSC_ST_REG_WRITE;
				else if (do_op & ~prot_hit)
					state_d = fsc_pkg::FSC_ST_ARRAY;
			fsc_pkg::FSC_ST_REG_WRITE:
				if (wr_cnt_q == 8'h01)
					state_d = fsc_pkg::FSC_ST_IDLE;
			fsc_pkg::FSC_ST_ARRAY:
				if (I_ARRAY_DONE)
					state_d = fsc_pkg::FSC_ST_IDLE;
				else if (do_susp)
					state_d = fsc_pkg::FSC_ST_SUSPENDED;
			fsc_pkg::FSC_ST_SUSPENDED:
				if (do_resume)
					state_d = fsc_pkg::FSC_ST_ARRAY;
			default:
				state_d = fsc_pkg::FSC_ST_IDLE;
		endcase
	end

	always_ff @(posedge I_CLK or negedge I_ARST_N)
	begin
		if (!I_ARST_N)
		begin
			state_q <= fsc_pkg::FSC_ST_IDLE;
			wr_cnt_q <= 8'h00;
			O_BUSY <= 1'b0;
			O_ARRAY_REQ <= 1'b0;
			O_ARRAY_HOLD <= 1'b0;
		end
		else if (I_CE)
		begin
			state_q <= state_d;
			if (do_rw)
				wr_cnt_q <= 8'(`FSC_REG_WRITE_CYC);
			else if (wr_cnt_q != 8'h00)
				wr_cnt_q <= wr_cnt_q - 8'h01;
			// R4: busy during operations
			// R5: clear only when idle or suspended
			O_BUSY <= (state_d == fsc_pkg::FSC_ST_REG_WRITE)
				| (state_d == fsc_pkg::FSC_ST_ARRAY);
			O_ARRAY_REQ <= (state_d == fsc_pkg::FSC_ST_ARRAY);
			O_ARRAY_HOLD <= (state_d == fsc_pkg::FSC_ST_SUSPENDED);
		end
	end

	always_ff @(posedge I_CLK or negedge I_ARST_N)
	begin
		if (!I_ARST_N)
		begin
			erase_kind_q <= 1'b0;
			sector_q <= 8'h00;
		end
		else if (I_CE && do_op)
		begin
			erase_kind_q <= (lk_req_q.cmd == fsc_pkg::FSC_CMD_ERASE);
			sector_q <= lk_req_q.sector;
		end
	end

	assign O_ARRAY_ERASE = erase_kind_q;
	assign O_ARRAY_SECTOR = sector_q;

	// ----------------------------------------
	// core domain: status fields
	// ----------------------------------------
	always_ff @(posedge I_CLK or negedge I_ARST_N)
	begin
		if (!I_ARST_N)
			wr_latch_q <= 1'b0;
		else if (I_CE)
		begin
			// R3: only enable and disable commands
			if (do_wen)
				wr_latch_q <= 1'b1;
			else if (do_wdis)
				wr_latch_q <= 1'b0;
		end
	end

	// R6: error flags, set beats clear
	always_ff @(posedge I_CLK or negedge I_ARST_N)
	begin
		if (!I_ARST_N)
		begin
			prog_err_q <= 1'b0;
			erase_err_q <= 1'b0;
		end
		else if (I_CE)
		begin
			if (do_clr)
			begin
				prog_err_q <= 1'b0;
				erase_err_q <= 1'b0;
			end
			if ((do_op & prot_hit
				& (lk_req_q.cmd == fsc_pkg::FSC_CMD_PROGRAM))
				| (O_ARRAY_REQ & I_ARRAY_DONE & I_ARRAY_FAIL
				& ~erase_kind_q))
				prog_err_q <= 1'b1;
			if ((do_op & prot_hit
				& (lk_req_q.cmd == fsc_pkg::FSC_CMD_ERASE))
				| (O_ARRAY_REQ & I_ARRAY_DONE & I_ARRAY_FAIL
				& erase_kind_q))
				erase_err_q <= 1'b1;
		end
	end

	always_ff @(posedge I_CLK or negedge I_ARST_N)
	begin
		if (!I_ARST_N)
		begin
			wr_disable_q <= 1'b0;
			range_q <= `FSC_RANGE_RST;
		end
		else if (I_CE && do_rw)
		begin
			wr_disable_q <= new_stat[`FSC_STAT_WRITE_DISABLE];
			// R12: frozen range ignores writes
			if (freeze_q)
				range_q <= range_q;
			// R8: volatile range comes up all ones
			else if (~volatile_q & new_cfg[`FSC_CFG_VOLATILITY])
				range_q <= `FSC_RANGE_VOL_DEFAULT;
			else
				range_q <= new_stat[`FSC_STAT_RANGE_HI:`FSC_STAT_RANGE_LO];
		end
	end

	// ----------------------------------------
	// core domain: configuration fields
	// ----------------------------------------
	// R15: reserved bits unstored
	always_ff @(posedge I_CLK or negedge I_ARST_N)
	begin
		if (!I_ARST_N)
		begin
			lat_q <= `FSC_LAT_RST;
			quad_q <= 1'b0;
			origin_q <= 1'b0;
			volatile_q <= 1'b0;
			freeze_q <= 1'b0;
		end
		else if (I_CE && do_rw)
		begin
			// R10: latency code
			lat_q <= new_cfg[`FSC_CFG_LAT_HI:`FSC_CFG_LAT_LO];
			// R11: four-lane select
			quad_q <= new_cfg[`FSC_CFG_QUAD];
			// R9: one-time bit, only zero to one, not when frozen
			if (~freeze_q & new_cfg[`FSC_CFG_ORIGIN])
				origin_q <= 1'b1;
			// R8: one-time volatility bit
			if (new_cfg[`FSC_CFG_VOLATILITY])
				volatile_q <= 1'b1;
			// R12: freeze sticks until reset
			if (new_cfg[`FSC_CFG_FREEZE])
				freeze_q <= 1'b1;
		end
	end

	assign O_LATENCY_CODE = lat_q;
	assign O_QUAD_MODE = quad_q;

	// ----------------------------------------
	// core domain: register snapshot to link
	// ----------------------------------------
	fsc_pkg::fsc_regs_t cur_regs;

	always_comb
	begin
		cur_regs = '0;
		cur_regs.status[`FSC_STAT_WRITE_DISABLE] = wr_disable_q;
		cur_regs.status[`FSC_STAT_PROG_ERR] = prog_err_q;
		cur_regs.status[`FSC_STAT_ERASE_ERR] = erase_err_q;
		cur_regs.status[`FSC_STAT_RANGE_HI:`FSC_STAT_RANGE_LO] = range_q;
		cur_regs.status[`FSC_STAT_WR_ENABLE] = wr_latch_q;
		cur_regs.status[`FSC_STAT_BUSY] = O_BUSY;
		cur_regs.cfg[`FSC_CFG_LAT_HI:`FSC_CFG_LAT_LO] = lat_q;
		cur_regs.cfg[`FSC_CFG_ORIGIN] = origin_q;
		cur_regs.cfg[`FSC_CFG_VOLATILITY] = volatile_q;
		cur_regs.cfg[`FSC_CFG_QUAD] = quad_q;
		cur_regs.cfg[`FSC_CFG_FREEZE] = freeze_q;
		// R13: erase suspended
		cur_regs.susp[`FSC_SUSP_ERASE] = O_ARRAY_HOLD & erase_kind_q;
		// R14: program suspended
		cur_regs.susp[`FSC_SUSP_PROG] = O_ARRAY_HOLD & ~erase_kind_q;
	end

	// word only changes after the link returned the last toggle
	always_ff @(posedge I_CLK or negedge I_ARST_N)
	begin
		if (!I_ARST_N)
		begin
			co_snap_q <= {`FSC_STAT_RST, `FSC_CFG_RST, `FSC_SUSP_RST};
			co_snap_tgl_q <= 1'b0;
		end
		else if (I_CE)
		begin
			if ((co_sack_q == co_snap_tgl_q) && (cur_regs != co_snap_q))
			begin
				co_snap_q <= cur_regs;
				co_snap_tgl_q <= ~co_snap_tgl_q;
			end
		end
	end

endmodule // fsc_regs

/* testbench/fsc_regs_sva.sv */
// assertions on the register bank ports
`timescale 1ns/1ps
`include "fsc_consts.svh"
module fsc_regs_sva (
	// core side inputs
	input wire logic I_CLK,
	input wire logic I_ARST_N,
	input wire logic I_CE,
	input wire logic I_ARRAY_DONE,
	// watched outputs
	input wire logic O_BUSY,
	input wire logic O_ARRAY_REQ,
	input wire logic O_ARRAY_HOLD,
	input wire logic O_ARRAY_ERASE,
	input wire logic [7:0] O_ARRAY_SECTOR,
	input wire logic [1:0] O_LATENCY_CODE,
	input wire logic O_QUAD_MODE
);
	localparam int WR_CYC = `FSC_REG_WRITE_CYC;
	logic [7:0] cnt_q;
	default clocking cb @(posedge I_CLK); endclocking
	default disable iff (!I_ARST_N);
	// ----
	// busy length, frozen cycles not counted
	// ----
	always_ff @(posedge I_CLK or negedge I_ARST_N)
	begin
		if (!I_ARST_N)
			cnt_q <= 8'h00;
		else if (!O_BUSY)
			cnt_q <= 8'h00;
		else if (I_CE)
			cnt_q <= cnt_q + 8'h01;
	end
	a_req_busy: assert property (O_ARRAY_REQ |-> O_BUSY)
		else $error("busy low during array op");
	a_busy_len: assert property ($fell(O_BUSY) && !$past(O_ARRAY_REQ)
		&& !O_ARRAY_HOLD |-> cnt_q == WR_CYC)
		else $error("register write busy length wrong");
	a_hold_idle: assert property (O_ARRAY_HOLD |-> !O_BUSY && !O_ARRAY_REQ)
		else $error("busy while suspended");
	a_done_ends: assert property (O_ARRAY_REQ && I_ARRAY_DONE
		|-> ##[1:2] (!O_ARRAY_REQ && !O_BUSY))
		else $error("op not ended by done");
	a_lat_write: assert property (!$stable(O_LATENCY_CODE) |-> $rose(O_BUSY))
		else $error("latency changed outside write");
	a_quad_write: assert property ($changed(O_QUAD_MODE) |-> $rose(O_BUSY))
		else $error("quad changed outside write");
	a_op_steady: assert property (O_ARRAY_REQ && $past(O_ARRAY_REQ)
		|-> $stable(O_ARRAY_SECTOR) && $stable(O_ARRAY_ERASE))
		else $error("sector moved during op");
	a_hold_entry: assert property ($rose(O_ARRAY_HOLD)
		|-> $past(O_ARRAY_REQ) && $stable(O_ARRAY_SECTOR))
		else $error("suspend without running op");
	c_reg_write: cover property ($fell(O_BUSY) && !O_ARRAY_HOLD);
	c_hold: cover property ($rose(O_ARRAY_HOLD));
	c_done: cover property (O_ARRAY_REQ && I_ARRAY_DONE);
endmodule // fsc_regs_sva

/* testbench/fsc_host.sv */
// host model issuing commands on the link
`timescale 1ns/1ps
module fsc_host (
	// link clock and handshake
	input wire logic i_link_clk,
	input wire logic i_ready,
	output logic o_valid,
	output fsc_pkg::fsc_cmd_req_t o_req
);
	initial
	begin
		o_valid = 1'b0;
		o_req = '0;
	end
	task automatic send(input fsc_pkg::fsc_cmd_req_t r, output bit ok);
		int n;
		n = 0;
		#1;
		o_valid = 1'b1;
		o_req = r;
		do
		begin
			@(posedge i_link_clk);
			n++;
		end
		while (i_ready !== 1'b1 && n < 400);
		#1;
		o_valid = 1'b0;
		// released bus shows the inverse, not stale data
		o_req = ~r;
		while (i_ready !== 1'b1 && n < 800)
		begin
			@(posedge i_link_clk);
			#1;
			n++;
		end
		ok = n < 800;
	endtask
endmodule // fsc_host

/* testbench/testbench.sv */
// self-checking bench of the register bank
`timescale 1ns/1ps
module testbench;
	logic clk = 1'b0;
	logic lclk = 1'b0;
	logic arst_n = 1'b0;
	logic wp_n = 1'b1;
	logic ce = 1'b1;
	logic done = 1'b0;
	logic fail = 1'b0;
	logic valid, ready, busy, req, hold, erase, quad;
	logic [7:0] sector;
	logic [1:0] lat;
	fsc_pkg::fsc_cmd_req_t lreq;
	fsc_pkg::fsc_regs_t regs;
	int err_total = 0;
	int checked = 0;
	always #12.5 clk = ~clk;
	initial #1.3 forever #3 lclk = ~lclk;
	fsc_regs fsc_regs_inst (.I_CLK(clk), .I_ARST_N(arst_n), .I_CE(ce),
		.I_LINK_CLK(lclk), .I_LINK_VALID(valid), .I_LINK_REQ(lreq),
		.O_LINK_READY(ready), .O_LINK_REGS(regs), .I_WP_N(wp_n),
		.I_ARRAY_DONE(done), .I_ARRAY_FAIL(fail), .O_ARRAY_REQ(req),
		.O_ARRAY_ERASE(erase), .O_ARRAY_SECTOR(sector), .O_ARRAY_HOLD(hold),
		.O_LATENCY_CODE(lat), .O_QUAD_MODE(quad), .O_BUSY(busy));
	fsc_host fsc_host_inst (.i_link_clk(lclk), .i_ready(ready),
		.o_valid(valid), .o_req(lreq));
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checked++;
		if (got !== exp)
		begin
			err_total++;
			$display("[FAIL] %0t got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic cmd(input fsc_pkg::fsc_cmd_t c,
		input logic [15:0] d = 16'h0000, input logic [7:0] s = 8'h00);
		bit ok;
		fsc_host_inst.send('{c, d, s}, ok);
		chk(ok, 1'b1);
		// snapshot lags the core by a few link cycles
		repeat (12) @(posedge lclk);
	endtask
	task automatic wr(input logic [15:0] d, input logic b);
		int n;
		cmd(fsc_pkg::FSC_CMD_REG_WRITE, d);
		chk(busy, b);
		n = 0;
		while (busy !== 1'b0 && n < 200)
		begin
			@(posedge clk);
			n++;
		end
		repeat (12) @(posedge lclk);
	endtask
	task automatic rg(input logic [7:0] s, c, p);
		chk(regs, {s, c, p});
	endtask
	task automatic fin(input logic f);
		@(posedge clk);
		#1 {done, fail} = {1'b1, f};
		@(posedge clk);
		#1 {done, fail} = 2'b00;
		repeat (12) @(posedge lclk);
	endtask
	task automatic end_of_test();
		$display("checks %0d errors %0d", checked, err_total);
		if (err_total == 0 && checked > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask
	initial
	begin
		#500000;
		err_total++;
		$display("[FAIL] %0t watchdog expired", $time);
		end_of_test();
	end
	initial
	begin
		repeat (6) @(posedge clk);
		#1 arst_n = 1'b1;
		repeat (8) @(posedge lclk);
		rg(8'h00, 8'h00, 8'h00);
		wr(16'h00C2, 1'b0);
		rg(8'h00, 8'h00, 8'h00);
		cmd(fsc_pkg::FSC_CMD_WR_ENABLE);
		wr(16'hE3D6, 1'b1);
		rg(8'h82, 8'hC2, 8'h00);
		chk({lat, quad}, 3'h7);
		@(posedge clk);
		#1 wp_n = 1'b0;
		wr(16'h0000, 1'b0);
		rg(8'h82, 8'hC2, 8'h00);
		@(posedge clk);
		#1 wp_n = 1'b1;
		wr(16'h1C02, 1'b1);
		rg(8'h1E, 8'h02, 8'h00);
		chk({lat, quad}, 3'h1);
		cmd(fsc_pkg::FSC_CMD_PROGRAM, 16'h0000, 8'h00);
		rg(8'h5E, 8'h02, 8'h00);
		cmd(fsc_pkg::FSC_CMD_CLEAR_ERR);
		wr(16'h0402, 1'b1);
		cmd(fsc_pkg::FSC_CMD_ERASE, 16'h0000, 8'hFC);
		rg(8'h26, 8'h02, 8'h00);
		cmd(fsc_pkg::FSC_CMD_CLEAR_ERR);
		cmd(fsc_pkg::FSC_CMD_ERASE, 16'h0000, 8'hFB);
		chk({req, erase, sector, busy}, {2'b11, 8'hFB, 1'b1});
		cmd(fsc_pkg::FSC_CMD_SUSPEND);
		rg(8'h06, 8'h02, 8'h02);
		chk({hold, busy}, 2'b10);
		cmd(fsc_pkg::FSC_CMD_RESUME);
		fin(1'b1);
		rg(8'h26, 8'h02, 8'h00);
		cmd(fsc_pkg::FSC_CMD_CLEAR_ERR);
		wr(16'h0422, 1'b1);
		cmd(fsc_pkg::FSC_CMD_PROGRAM, 16'h0000, 8'h03);
		rg(8'h46, 8'h22, 8'h00);
		cmd(fsc_pkg::FSC_CMD_CLEAR_ERR);
		cmd(fsc_pkg::FSC_CMD_PROGRAM, 16'h0000, 8'h04);
		cmd(fsc_pkg::FSC_CMD_SUSPEND);
		rg(8'h06, 8'h22, 8'h01);
		cmd(fsc_pkg::FSC_CMD_RESUME);
		fin(1'b0);
		rg(8'h06, 8'h22, 8'h00);
		wr(16'h002A, 1'b1);
		rg(8'h1E, 8'h2A, 8'h00);
		// frozen clock enable stretches the register write
		cmd(fsc_pkg::FSC_CMD_REG_WRITE, 16'h1C2B);
		@(posedge clk);
		#1 ce = 1'b0;
		repeat (90) @(posedge clk);
		#1 chk(busy, 1'b1);
		ce = 1'b1;
		while (busy !== 1'b0)
			@(posedge clk);
		repeat (12) @(posedge lclk);
		wr(16'h004B, 1'b1);
		rg(8'h1E, 8'h6B, 8'h00);
		cmd(fsc_pkg::FSC_CMD_WR_DISABLE);
		wr(16'h0000, 1'b0);
		cmd(fsc_pkg::FSC_CMD_ERASE, 16'h0000, 8'h10);
		chk(req, 1'b0);
		rg(8'h1C, 8'h6B, 8'h00);
		end_of_test();
	end
endmodule // testbench

bind fsc_regs fsc_regs_sva fsc_regs_sva_inst (.I_CLK(I_CLK),
	.I_ARST_N(I_ARST_N), .I_CE(I_CE), .I_ARRAY_DONE(I_ARRAY_DONE),
	.O_BUSY(O_BUSY), .O_ARRAY_REQ(O_ARRAY_REQ),
	.O_ARRAY_HOLD(O_ARRAY_HOLD), .O_ARRAY_ERASE(O_ARRAY_ERASE),
	.O_ARRAY_SECTOR(O_ARRAY_SECTOR), .O_LATENCY_CODE(O_LATENCY_CODE),
	.O_QUAD_MODE(O_QUAD_MODE));
